// file: hdl/strap_led_pkg.sv
package strap_led_pkg;

    // ------------------------------------------------------------
    // pin positions and timing
    // ------------------------------------------------------------
    localparam int unsigned PIN_COUNT       = 3;
    localparam int unsigned PIN_ACTIVITY    = 0;
    localparam int unsigned PIN_COLLISION   = 1;
    localparam int unsigned PIN_LINK        = 2;
    localparam logic [2:0]  STRAP_RESET_VAL = 3'h0;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned COL_STRETCH_MS  = 70;
    localparam int unsigned COL_STRETCH_CYC = COL_STRETCH_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned COL_CNT_W       = 23;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rx_active;
        logic tx_active;
        logic collision;
        logic link_up;
    } status_in_t;

    typedef struct packed {
        logic [PIN_COUNT-1:0] level_in;
    } pin_in_t;

    typedef struct packed {
        logic [PIN_COUNT-1:0] level_out;
        logic [PIN_COUNT-1:0] oe_n;
    } pin_out_t;

    typedef enum logic [1:0] {
        ST_STRAP = 2'b01,
        ST_DRIVE = 2'b10
    } pin_state_t;

endpackage : strap_led_pkg

// file: hdl/collision_stretch.sv
`timescale 1ns/1ns
module collision_stretch
    import strap_led_pkg::*;
#(
    parameter int unsigned STRETCH_CYC = COL_STRETCH_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // collision in, stretched indication out
    input  wire logic collision,
    output logic      stretched
);

    logic [COL_CNT_W-1:0] count;
    logic [COL_CNT_W-1:0] next_count;
    logic                 next_stretched;

    // reload on every collision, count down afterwards
    always_comb begin
        next_count     = count;
        next_stretched = stretched;
        if (collision) begin
            next_count     = COL_CNT_W'(STRETCH_CYC - 1);
            next_stretched = 1'b1;
        end else if (count != '0) begin
            next_count     = count - 1'b1;
            next_stretched = 1'b1;
        end else begin
            next_stretched = 1'b0;
        end
    end

    // registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count     <= '0;
            stretched <= 1'b0;
        end else begin
            count     <= next_count;
            stretched <= next_stretched;
        end
    end

endmodule : collision_stretch

// file: hdl/strap_led_pin_sharing.sv
// Functional notes
// - during hardware reset pins are inputs; level sampled on reset exit.
// - after the sample is taken every shared pin becomes an output.
// - software reset neither resamples nor alters captured values; pins stay outputs.
// - asserted indication drives inverse of sampled level; deasserted drives sampled level.
// - low sample gives address bit zero, high sample gives one.
// - bit 0 from activity pin, bit 1 collision pin, bit 2 link pin.
// - activity indication is receive or transmit activity.
// - collision indication stretched about 70 ms, drops when no collision seen.
// - link indication follows valid link status.
`timescale 1ns/1ns
module strap_led_pin_sharing
    import strap_led_pkg::*;
#(
    parameter int unsigned STRETCH_CYC = COL_STRETCH_CYC
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   soft_reset,
    // status from the phy core
    input  wire strap_led_pkg::status_in_t status,
    // shared pins
    input  wire strap_led_pkg::pin_in_t  pins_in,
    output strap_led_pkg::pin_out_t      pins_out,
    // captured address bits 0 to 2
    output logic [2:0]                  phy_strap_address
);

    import strap_led_pkg::*;

    // ------------------------------------------------------------
    // timing at a glance
    // ------------------------------------------------------------
    // reset_n low: every pin released, address cleared
    // first edge after release: strap loaded, pins start to drive
    // strap is the pin level two edges before that first edge,
    // so the pulls must settle while reset_n is still low
    // activity and link reach the pins three edges after status moves
    // collision reaches its pin one edge later, through the stretcher
    // soft_reset darkens activity and link, never releases a pin
    // the leds sit in series with the pulls: driving the inverse of
    // the strap lights them, driving the strap level keeps them dark
    // pins_in is not read again once the strap is loaded
    // a hardware reset in mid-run releases the pins at once,
    // and the next release samples the pulls afresh

    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] sync_a;
    logic [PIN_COUNT-1:0] sync_b;
    logic [PIN_COUNT-1:0] next_sync_a;
    logic [PIN_COUNT-1:0] next_sync_b;

    // next values; the pins are board levels, foreign to clk
    always_comb begin
        next_sync_a = pins_in.level_in;
        next_sync_b = sync_a;
    end

    // no reset: the chain tracks the pulls while reset_n is low,
    // else the first edge after release would capture zeros
    always_ff @(posedge clk) begin
        sync_a <= next_sync_a;
        sync_b <= next_sync_b;
    end

    // ------------------------------------------------------------
    // status synchroniser
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] status_raw;
    logic [PIN_COUNT-1:0] status_a;
    logic [PIN_COUNT-1:0] status_b;
    logic [PIN_COUNT-1:0] next_status_a;
    logic [PIN_COUNT-1:0] next_status_b;

    // one bit per pin; activity is receive or transmit
    always_comb begin
        status_raw                = '0;
        status_raw[PIN_ACTIVITY]  = status.rx_active | status.tx_active;
        status_raw[PIN_COLLISION] = status.collision;
        status_raw[PIN_LINK]      = status.link_up;
    end

    // next values; status comes from other clocks of the core
    always_comb begin
        next_status_a = status_raw;
        next_status_b = status_a;
    end

    // status starts idle so no indication flashes on release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_a <= '0;
            status_b <= '0;
        end else begin
            status_a <= next_status_a;
            status_b <= next_status_b;
        end
    end

    // ------------------------------------------------------------
    // pin direction
    // ------------------------------------------------------------
    pin_state_t           state;
    pin_state_t           next_state;

    // sampling lasts one edge, then the pins drive for good
    always_comb begin
        next_state = state;
        unique case (state)
            ST_STRAP: begin
                next_state = ST_DRIVE;
            end
            ST_DRIVE: begin
                next_state = ST_DRIVE;
            end
            default: begin
                next_state = ST_STRAP;
            end
        endcase
    end

    // direction register, cleared only by hardware reset;
    // a software reset never sends the pins back to inputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_STRAP;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    logic [2:0]           next_strap;

    // strap loads once, on the edge that leaves the sampling state
    always_comb begin
        next_strap = phy_strap_address;
        if (state == ST_STRAP) begin
            next_strap = sync_b;
        end
    end

    // soft_reset deliberately not used, so the strap survives it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phy_strap_address <= STRAP_RESET_VAL;
        end else begin
            phy_strap_address <= next_strap;
        end
    end

    // ------------------------------------------------------------
    // collision stretch
    // ------------------------------------------------------------
    logic col_stretched;

    // a short collision lights its led long enough to be seen;
    // every new collision restarts the hold, so bursts merge
    collision_stretch #(
        .STRETCH_CYC (STRETCH_CYC)
    ) u_col (
        .clk       (clk),
        .reset_n   (reset_n),
        .collision (status_b[PIN_COLLISION]),
        .stretched (col_stretched)
    );

    // ------------------------------------------------------------
    // indications
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] indication;

    // indication per pin; software reset darkens activity and link,
    // the collision stretch keeps running through it
    always_comb begin
        indication                = '0;
        indication[PIN_ACTIVITY]  = status_b[PIN_ACTIVITY] & ~soft_reset;
        indication[PIN_COLLISION] = col_stretched;
        indication[PIN_LINK]      = status_b[PIN_LINK] & ~soft_reset;
    end

    // ------------------------------------------------------------
    // per-pin drive
    // ------------------------------------------------------------
    logic                 driving;
    wire  [PIN_COUNT-1:0] next_level;
    wire  [PIN_COUNT-1:0] next_oe_n;
    pin_out_t             next_pins_out;

    // pins turn to outputs on the edge that captures the strap
    assign driving = (next_state == ST_DRIVE);

    // one slice per shared pin
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        // released: no level; driven: indication xor captured strap
        assign next_level[i] = driving & (indication[i] ^ next_strap[i]);
        // low while the pin drives its led
        assign next_oe_n[i]  = ~driving;
    end

    // pack the slices for the output register
    always_comb begin
        next_pins_out.level_out = next_level;
        next_pins_out.oe_n      = next_oe_n;
    end

    // pins released (oe_n high) through hardware reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_out <= '{level_out: '0, oe_n: '1};
        end else begin
            pins_out <= next_pins_out;
        end
    end

endmodule : strap_led_pin_sharing

// file: testbench/board_leds.sv
`timescale 1ns/1ns
module board_leds
    import strap_led_pkg::*;
(
    // pull levels and pin drive
    input  wire logic [2:0]              pull,
    input  wire strap_led_pkg::pin_out_t pins_out,
    output strap_led_pkg::pin_in_t       pins_in
);
    // released pin follows its pull, driven pin its drive
    always_comb begin
        pins_in.level_in = (pins_out.oe_n & pull) | (~pins_out.oe_n & pins_out.level_out);
    end
endmodule : board_leds

// file: testbench/strap_led_checker.sv
`timescale 1ns/1ns
module strap_led_checker
    import strap_led_pkg::*;
#(
    parameter int unsigned STRETCH_CYC = 16
) (
    // design ports
    input wire logic                       clk,
    input wire logic                       reset_n,
    input wire logic                       soft_reset,
    input wire strap_led_pkg::status_in_t  status,
    input wire strap_led_pkg::pin_in_t     pins_in,
    input wire strap_led_pkg::pin_out_t    pins_out,
    input wire logic [2:0]                 phy_strap_address
);
    logic [31:0] quiet;
    logic [31:0] next_quiet;
    // cycles since the last collision, saturating
    always_comb next_quiet = status.collision ? 32'h0 : quiet + {31'h0, ~&quiet};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quiet <= 32'hffff_ffff;
        end else begin
            quiet <= next_quiet;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    strap_in_a: assert property ($rose(reset_n) |-> pins_out.oe_n == 3'h7)
        else $error("pins driven in reset");
    drive_on_a: assert property ($rose(reset_n) |=> pins_out.oe_n == 3'h0)
        else $error("pins not driven after reset");
    addr_take_a: assert property ($rose(reset_n) |=>
        phy_strap_address == $past(pins_in.level_in, 3)) else $error("bad strap");
    addr_keep_a: assert property (pins_out.oe_n == 3'h0 |=>
        pins_out.oe_n == 3'h0 && $stable(phy_strap_address)) else $error("strap lost");
    act_led_a: assert property ((pins_out.oe_n == 3'h0 && !soft_reset)[*6] |->
        pins_out.level_out[0] == (phy_strap_address[0] ^
        ($past(status.rx_active, 3) | $past(status.tx_active, 3)))) else $error("activity");
    link_led_a: assert property ((pins_out.oe_n == 3'h0 && !soft_reset)[*6] |->
        pins_out.level_out[2] == (phy_strap_address[2] ^ $past(status.link_up, 3)))
        else $error("link");
    col_hold_a: assert property (quiet >= 4 && quiet < STRETCH_CYC |->
        pins_out.level_out[1] != phy_strap_address[1]) else $error("collision short");
    col_off_a: assert property (quiet > STRETCH_CYC + 6 |->
        pins_out.level_out[1] == phy_strap_address[1]) else $error("collision long");
endmodule : strap_led_checker

bind strap_led_pin_sharing strap_led_checker #(.STRETCH_CYC(STRETCH_CYC)) u_strap_led_checker (
    .clk(clk), .reset_n(reset_n), .soft_reset(soft_reset), .status(status),
    .pins_in(pins_in), .pins_out(pins_out), .phy_strap_address(phy_strap_address));

// file: testbench/strap_led_pin_sharing_test.sv
`timescale 1ns/1ns
module strap_led_pin_sharing_test;
    import strap_led_pkg::*;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       soft_reset = 1'b0;
    status_in_t status = '0;
    logic [2:0] pull = 3'h0;
    pin_in_t    pins_in;
    pin_out_t   pins_out;
    logic [2:0] phy_strap_address;
    int         n_errors = 0;
    int         total_checks = 0;
    // 100 MHz clock
    always #5 clk = ~clk;
    strap_led_pin_sharing #(.STRETCH_CYC(16)) u_strap_led_pin_sharing (.clk(clk),
        .reset_n(reset_n), .soft_reset(soft_reset), .status(status), .pins_in(pins_in),
        .pins_out(pins_out), .phy_strap_address(phy_strap_address));
    board_leds u_board_leds (.pull(pull), .pins_out(pins_out), .pins_in(pins_in));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // expected pin levels: indication xor strap
    function automatic logic [2:0] led(input status_in_t s, input logic [2:0] p);
        return {s.link_up, s.collision, s.rx_active | s.tx_active} ^ p;
    endfunction : led
    task automatic complete_run;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // watchdog
    initial begin
        #50000;
        n_errors++;
        complete_run();
    end
    // strap corners then random straps, each with led and soft reset traffic
    initial begin
        void'($urandom(54837));
        for (int k = 0; k < 6; k++) begin
            reset_n = 1'b0;
            status = '0;
            pull = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : 3'($urandom);
            step(k == 0 ? 16 : 4);
            chk(pins_out.oe_n, 3'h7);
            reset_n = 1'b1;
            step(2);
            chk(phy_strap_address, pull);
            chk(pins_out.oe_n, 3'h0);
            for (int j = 0; j < 10; j++) begin
                status = 4'($urandom) & 4'hd;
                step(4);
                chk(pins_out.level_out, led(status, pull));
            end
            soft_reset = 1'b1;
            status = 4'h2;
            step(1);
            status = 4'h9;
            step(6);
            chk(pins_out.oe_n, 3'h0);
            chk(phy_strap_address, pull);
            chk(pins_out.level_out, {pull[2], ~pull[1], pull[0]});
            soft_reset = 1'b0;
            step(24);
            chk(pins_out.level_out, led(status, pull));
            $display("test %0d done", k);
        end
        complete_run();
    end
endmodule : strap_led_pin_sharing_test
